// *** design/divq_top.sv ***
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - HDLC status byte: bit7 one, overflow b6, check b5, abort b4, rest zero
// - Status byte is built at frame end and stored as last frame byte
// - Check flag is 0 on failed frame check, 1 on good frame
// - Overflow flag set when data was lost during the frame
// - Abort flag set when sender aborted the frame
// - Async char entry: data 7:0, parity bit 8, framing_error_flag 14, parity_error_flag 15
// - Vectors buffered in 32-doubleword FIFO before transfer
// - Each vector written to one of nine queues by source identifier
// - Per-queue new flags; host writes one to confirm, zero no effect
// - INTA asserted on new event, held until all flags confirmed
// - Per-queue base register; length via two shared regs, 32-dword units
// - One queue per channel and direction, plus configuration queue
// - Masked source gives no vector, no INTA, no flag
// - Host-requested irq raised on descriptor completion at branch time
// - Frame irq on frame-end completion; rx also on reset stop
// - Rx error on frame not fitting with hold, or reset abort
// - Tx error without frame flag: hold, last=first, or zero count, no FE
// - Engine continues normally after an error irq
// - Frame and host-requested from same descriptor merged in one vector
// - Config vector: id 1010 in 31:28, zeros, bit1 failed, bit0 done
// - DMA vector: bit31 zero, 3-bit id, flags in 18, 17, 16
// - Channel vector: type 0010 in 27:24, status in low bits
// - Channel vector bits 18:0 copy channel status at generation
module divq_top
  import divq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [5:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Descriptor completion events, one per DMA source (rx0-3, tx0-3)
  input wire logic [7:0] desc_done_in,
  input wire logic [7:0] desc_host_irq_in,
  input wire logic [7:0] desc_frame_end_in,
  input wire logic [7:0] desc_hold_in,
  input wire logic [7:0] desc_last_eq_first_in,
  input wire logic [7:0] desc_count_zero_in,
  input wire logic [7:0] desc_no_fit_in,
  input wire logic [3:0] rx_reset_stop_in,
  input wire logic [3:0] rx_dma_reset_cmd_in,
  // Action request completion
  input wire logic action_request_done_in,
  input wire logic action_request_failed_in,
  // Serial channel events with status snapshot, one per source
  input wire logic [7:0] chan_irq_in,
  input wire logic [7:0][18:0] channel_irq_status_in,
  // HDLC frame end status
  input wire logic [3:0] hdlc_frame_end_in,
  input wire logic [3:0] receive_overflow_flag_in,
  input wire logic [3:0] crc_ok_in,
  input wire logic [3:0] frame_aborted_flag_in,
  output logic [3:0] fsb_valid_out,
  output logic [3:0][7:0] frame_status_byte_out,
  // Async characters
  input wire logic [3:0] char_valid_in,
  input wire logic [3:0][7:0] char_data_in,
  input wire logic [3:0] char_parity_in,
  input wire logic [3:0] parity_error_flag_in,
  input wire logic [3:0] framing_error_flag_in,
  input wire logic [3:0] char_status_store_enable_in,
  output logic [3:0] char_valid_out,
  output logic [3:0][15:0] char_entry_out,
  // Shared memory write master
  output logic mem_wr_valid_out,
  input wire logic mem_wr_ready_in,
  output logic [31:0] mem_wr_addr_out,
  output logic [31:0] mem_wr_data_out,
  output logic vec_dropped_out,
  output logic inta_n_out
);
  typedef struct packed {
    logic [NUM_QUEUES-1:0][31:0] qbase;
    logic [NUM_QUEUES-1:0][12:0] qpos; // Longest queue has 8192 entries
    logic [31:0] qlen0;
    logic [31:0] qlen1;
    logic [31:0] mask;
    logic [NUM_QUEUES-1:0] global_queue_flags;
    logic [31:0] rdata;
    logic mem_valid;
    logic [31:0] mem_addr;
    logic [31:0] mem_data;
    logic [3:0] cur_q;
    logic [3:0] fsb_valid;
    logic [3:0][7:0] fsb;
    logic [3:0] ch_valid;
    logic [3:0][15:0] ch_entry;
    logic dropped;
  } divq_state_type;

  divq_state_type st_r, st_nxt;
  logic [7:0] dma_ev;
  logic [7:0][31:0] dma_vec;
  logic [7:0][31:0] scc_vec;
  logic cfg_ev;
  logic [31:0] cfg_vec;
  logic in_valid, in_ready, out_valid, out_ready;
  logic [31:0] in_data, out_data;
  logic [5:0] level;
  logic [3:0] out_q;
  logic [7:0] qlen_field;

  // Build DMA vectors; engine keeps running after errors since nothing here
  // stalls it
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic hi, fi, er;
      hi = desc_done_in[i] && desc_host_irq_in[i];
      fi = desc_done_in[i] && desc_frame_end_in[i];
      er = 1'b0;
      if (i < NUM_CHAN) begin
        fi = fi || (rx_reset_stop_in[i]);
        er = (desc_no_fit_in[i] && desc_hold_in[i]) ||
          rx_dma_reset_cmd_in[i];
      end else begin
        er = desc_done_in[i] && !desc_frame_end_in[i] &&
          (desc_hold_in[i] || desc_last_eq_first_in[i] ||
          desc_count_zero_in[i]);
      end
      dma_vec[i] = '0;
      dma_vec[i][30:SRC_LO] = 3'(i);
      dma_vec[i][DMA_HI_BIT] = hi;
      dma_vec[i][DMA_FI_BIT] = fi;
      dma_vec[i][DMA_ERR_BIT] = er;
      dma_ev[i] = (hi || fi || er) && !st_r.mask[i];
      scc_vec[i] = {1'b0, 3'(i), SCC_TYPE_CODE, 5'h00,
        channel_irq_status_in[i]};
    end
  end

  // Configuration vector
  assign cfg_vec = {CFG_SRC_ID, 26'h0000000, action_request_failed_in,
    action_request_done_in};
  assign cfg_ev = (action_request_done_in || action_request_failed_in) &&
    !st_r.mask[16];

  // Pick one event per cycle: config, then DMA, then channel; losers are
  // lost uncounted, as the producers have no back-pressure; dropped only marks a pick the full store refuses
  always_comb begin
    in_valid = 1'b0;
    in_data = '0;
    if (cfg_ev) begin
      in_valid = 1'b1;
      in_data = cfg_vec;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        if (chan_irq_in[i] && !st_r.mask[8+i]) begin
          in_valid = 1'b1;
          in_data = scc_vec[i];
        end
      end
      for (int i = 7; i >= 0; i--) begin
        if (dma_ev[i]) begin
          in_valid = 1'b1;
          in_data = dma_vec[i];
        end
      end
    end
  end

  // Vector store
  divq_vec_fifo #(
    .WIDTH(32),
    .DEPTH(VFIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .wr_valid_in(in_valid),
    .wr_ready_out(in_ready),
    .wr_data_in(in_data),
    .rd_valid_out(out_valid),
    .rd_ready_in(out_ready),
    .rd_data_out(out_data),
    .level_out(level)
  );

  // Queue select from source id
  always_comb begin
    if (out_data[31:SRC_LO] == CFG_SRC_ID) begin
      out_q = 4'(CFG_QUEUE);
    end else begin
      out_q = {1'b0, out_data[30:SRC_LO]};
    end
  end
  assign out_ready = !st_r.mem_valid || mem_wr_ready_in;

  // Length of selected queue, 8 bits per queue in the two shared regs; queue 8 uses the queue 7 byte (qlen1 31:24)
  always_comb begin
    if (out_q < 4'd4) begin
      qlen_field = st_r.qlen0[out_q[1:0]*8 +: 8];
    end else if (out_q < 4'd8) begin
      qlen_field = st_r.qlen1[out_q[1:0]*8 +: 8];
    end else begin
      qlen_field = st_r.qlen1[31:24];
    end
  end

  // Next state
  always_comb begin
    logic [13:0] qend;
    qend = 14'({qlen_field, 5'h00}) + 14'(QLEN_UNIT);
    st_nxt = st_r;
    st_nxt.dropped = in_valid && !in_ready;
    if (mem_wr_ready_in) begin
      st_nxt.mem_valid = 1'b0;
    end
    if (out_valid && out_ready) begin
      st_nxt.mem_valid = 1'b1;
      st_nxt.mem_data = out_data;
      st_nxt.mem_addr = st_r.qbase[out_q] +
        32'({st_r.qpos[out_q], 2'b00});
      st_nxt.cur_q = out_q;
      if (14'(st_r.qpos[out_q]) + 14'd1 >= qend) begin
        st_nxt.qpos[out_q] = '0;
      end else begin
        st_nxt.qpos[out_q] = st_r.qpos[out_q] + 13'd1;
      end
    end
    // Flag set on delivery; confirm write clears, set wins
    if (reg_wr_in && reg_addr_in == REG_GLOBAL_FLAGS) begin
      st_nxt.global_queue_flags = st_r.global_queue_flags &
        ~reg_wdata_in[NUM_QUEUES-1:0];
    end
    if (st_r.mem_valid && mem_wr_ready_in) begin
      st_nxt.global_queue_flags[st_r.cur_q] = 1'b1;
    end
    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_QLEN0: st_nxt.qlen0 = reg_wdata_in;
        REG_QLEN1: st_nxt.qlen1 = reg_wdata_in;
        REG_MASK: st_nxt.mask = reg_wdata_in;
        default: begin
          if (reg_addr_in >= REG_QBASE0 &&
            reg_addr_in < REG_QBASE0 + 6'(NUM_QUEUES)) begin
            st_nxt.qbase[4'(reg_addr_in - REG_QBASE0)] =
              {reg_wdata_in[31:2], 2'b00};
            st_nxt.qpos[4'(reg_addr_in - REG_QBASE0)] = '0;
          end
        end
      endcase
    end
    // Register reads, data the next cycle
    st_nxt.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_GLOBAL_FLAGS: st_nxt.rdata = 32'(st_r.global_queue_flags);
        REG_QLEN0: st_nxt.rdata = st_r.qlen0;
        REG_QLEN1: st_nxt.rdata = st_r.qlen1;
        REG_MASK: st_nxt.rdata = st_r.mask;
        REG_FIFO_LEVEL: st_nxt.rdata = 32'(level);
        default: begin
          if (reg_addr_in >= REG_QBASE0 &&
            reg_addr_in < REG_QBASE0 + 6'(NUM_QUEUES)) begin
            st_nxt.rdata = st_r.qbase[4'(reg_addr_in - REG_QBASE0)];
          end else if (reg_addr_in >= REG_QPOS0 &&
            reg_addr_in < REG_QPOS0 + 6'(NUM_QUEUES)) begin
            st_nxt.rdata = 32'(st_r.qpos[4'(reg_addr_in - REG_QPOS0)]);
          end
        end
      endcase
    end
    // Status byte at frame end and async character entries
    for (int c = 0; c < NUM_CHAN; c++) begin
      st_nxt.fsb_valid[c] = hdlc_frame_end_in[c];
      if (hdlc_frame_end_in[c]) begin
        st_nxt.fsb[c] = 8'h00;
        st_nxt.fsb[c][FSB_MARK_BIT] = 1'b1;
        st_nxt.fsb[c][FSB_OVF_BIT] = receive_overflow_flag_in[c];
        st_nxt.fsb[c][FSB_CRC_BIT] = crc_ok_in[c];
        st_nxt.fsb[c][FSB_ABT_BIT] = frame_aborted_flag_in[c];
      end
      st_nxt.ch_valid[c] = char_valid_in[c];
      if (char_valid_in[c]) begin
        st_nxt.ch_entry[c] = {8'h00, char_data_in[c]};
        if (char_status_store_enable_in[c]) begin
          st_nxt.ch_entry[c][CHS_PAR_BIT] = char_parity_in[c];
          st_nxt.ch_entry[c][CHS_FRAMING_ERROR_FLAG_BIT] = framing_error_flag_in[c];
          st_nxt.ch_entry[c][CHS_PARITY_ERROR_FLAG_BIT] = parity_error_flag_in[c];
        end
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.mask <= MASK_RESET;
      st_r.qlen0 <= QLEN_RESET;
      st_r.qlen1 <= QLEN_RESET;
    end else if (clk_en_in) begin
      st_r <= st_nxt;
    end
  end

  // Outputs; INTA low while any queue flag is pending
  assign inta_n_out = ~|st_r.global_queue_flags;
  assign reg_rdata_out = st_r.rdata;
  assign mem_wr_valid_out = st_r.mem_valid;
  assign mem_wr_addr_out = st_r.mem_addr;
  assign mem_wr_data_out = st_r.mem_data;
  assign vec_dropped_out = st_r.dropped;
  assign fsb_valid_out = st_r.fsb_valid;
  assign frame_status_byte_out = st_r.fsb;
  assign char_valid_out = st_r.ch_valid;
  assign char_entry_out = st_r.ch_entry;
endmodule
`default_nettype wire

// *** design/divq_vec_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
// Vector store in flip-flops; full and empty are exact
module divq_vec_fifo
  import divq_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = VFIFO_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } divq_fifo_state_type;
  divq_fifo_state_type st_r, st_nxt;
  logic push, pop;

  // Handshakes are combinational from the count
  assign wr_ready_out = (st_r.cnt != (AW+1)'(DEPTH));
  assign rd_valid_out = (st_r.cnt != '0);
  assign rd_data_out = st_r.mem[st_r.rp];
  assign level_out = st_r.cnt;
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  // Next state
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = wr_data_in;
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + AW'(1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + AW'(1);
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - (AW+1)'(1);
    end
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else if (clk_en_in) begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// *** include/divq_pkg.sv ***
package divq_pkg;
  // Queue count and vector layout
  localparam int NUM_QUEUES = 9;
  localparam int NUM_CHAN = 4;
  localparam int CFG_QUEUE = 8;
  localparam int VFIFO_DEPTH = 32;
  localparam int QLEN_UNIT = 32;
  localparam logic [3:0] CFG_SRC_ID = 4'ha;
  localparam logic [3:0] SCC_TYPE_CODE = 4'h2;
  localparam int DMA_HI_BIT = 18;
  localparam int DMA_FI_BIT = 17;
  localparam int DMA_ERR_BIT = 16;
  localparam int SRC_LO = 28;
  // Status byte and async char entry fields
  localparam int FSB_MARK_BIT = 7;
  localparam int FSB_OVF_BIT = 6;
  localparam int FSB_CRC_BIT = 5;
  localparam int FSB_ABT_BIT = 4;
  localparam int CHS_PAR_BIT = 8;
  localparam int CHS_FRAMING_ERROR_FLAG_BIT = 14;
  localparam int CHS_PARITY_ERROR_FLAG_BIT = 15;
  // Register indices (word addresses)
  localparam logic [5:0] REG_GLOBAL_FLAGS = 6'h00;
  localparam logic [5:0] REG_QLEN0 = 6'h01;
  localparam logic [5:0] REG_QLEN1 = 6'h02;
  localparam logic [5:0] REG_MASK = 6'h03;
  localparam logic [5:0] REG_FIFO_LEVEL = 6'h04;
  localparam logic [5:0] REG_QBASE0 = 6'h10;
  localparam logic [5:0] REG_QPOS0 = 6'h20;
  // Reset values
  localparam logic [31:0] QBASE_RESET = 32'h0000_0000;
  localparam logic [31:0] QLEN_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
endpackage

// *** test/divq_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module divq_checker
  import divq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic reg_wr_in,
  input wire logic [3:0] hdlc_frame_end_in,
  input wire logic [3:0] receive_overflow_flag_in,
  input wire logic [3:0] crc_ok_in,
  input wire logic [3:0] frame_aborted_flag_in,
  input wire logic [3:0] fsb_valid_out,
  input wire logic [3:0][7:0] frame_status_byte_out,
  input wire logic mem_wr_valid_out,
  input wire logic mem_wr_ready_in,
  input wire logic [31:0] mem_wr_addr_out,
  input wire logic [31:0] mem_wr_data_out,
  input wire logic inta_n_out
);
  // Short aliases keep the vector checks readable
  wire v = mem_wr_valid_out;
  wire [31:0] d = mem_wr_data_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Status byte one cycle after frame end, flags in fixed places
  fsb_byte_a: assert property (
    clk_en_in && hdlc_frame_end_in[0] |=> fsb_valid_out[0] &&
    frame_status_byte_out[0] == {1'b1, $past(receive_overflow_flag_in[0]),
    $past(crc_ok_in[0]), $past(frame_aborted_flag_in[0]), 4'h0})
    else $error("status byte wrong");
  fsb_quiet_a: assert property (
    clk_en_in && !hdlc_frame_end_in[0] |=> !fsb_valid_out[0])
    else $error("status byte without frame end");
  // A stalled write must not change under the host
  mem_hold_a: assert property (
    v && !mem_wr_ready_in |=> v && $stable(d) && $stable(mem_wr_addr_out))
    else $error("queue write changed while stalled");
  inta_set_a: assert property (
    clk_en_in && v && mem_wr_ready_in |=> !inta_n_out)
    else $error("interrupt line not raised");
  // Line may only drop after a host confirm write
  inta_clr_a: assert property (
    $rose(inta_n_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("interrupt line released without confirm");
  dma_vec_a: assert property (
    v && !d[31] && d[27:24] != SCC_TYPE_CODE |->
    d[27:19] == 9'h0 && d[15:0] == 16'h0)
    else $error("dma vector reserved bits set");
  cfg_vec_a: assert property (
    v && d[31:28] == CFG_SRC_ID |-> d[27:2] == 26'h0)
    else $error("config vector reserved bits set");
  chan_vec_a: assert property (
    v && !d[31] && d[27:24] == SCC_TYPE_CODE |-> d[23:19] == 5'h0)
    else $error("channel vector reserved bits set");
  fsb_c: cover property (fsb_valid_out[0]);
  wr_c: cover property (v && !mem_wr_ready_in ##1 v && mem_wr_ready_in);
  clr_c: cover property ($rose(inta_n_out));
endmodule
bind divq_top divq_checker chk (.*);
`default_nettype wire

// *** test/divq_host_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
module divq_host_mem (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic mem_wr_valid_in,
  input wire logic [31:0] mem_wr_addr_in,
  input wire logic [31:0] mem_wr_data_in,
  input wire logic stall_in,
  input wire logic slow_in,
  output logic mem_wr_ready_out
);
  logic [31:0] wa [0:63];
  logic [31:0] wd [0:63];
  int n;
  logic tog_r;
  // Slow host accepts every other cycle, so writes must be held
  assign mem_wr_ready_out = !stall_in && (!slow_in || tog_r);
  // Log of accepted writes, checked by the bench in order
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_r <= 1'b0;
      n <= 0;
    end else begin
      tog_r <= !tog_r;
      if (mem_wr_valid_in && mem_wr_ready_out && n < 64) begin
        wa[n] <= mem_wr_addr_in;
        wd[n] <= mem_wr_data_in;
        n <= n + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import divq_pkg::*;
;
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, clk_en_in = 1'b1;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [5:0] reg_addr_in = 6'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic [7:0] desc_done_in, desc_host_irq_in, desc_frame_end_in;
  logic [7:0] desc_hold_in, desc_last_eq_first_in, desc_count_zero_in;
  logic [7:0] desc_no_fit_in, chan_irq_in;
  logic [7:0][18:0] channel_irq_status_in;
  logic [3:0] rx_reset_stop_in, rx_dma_reset_cmd_in, hdlc_frame_end_in;
  logic [3:0] receive_overflow_flag_in, crc_ok_in, frame_aborted_flag_in;
  logic [3:0] char_valid_in, char_parity_in, parity_error_flag_in;
  logic [3:0] framing_error_flag_in, char_status_store_enable_in;
  logic [3:0][7:0] char_data_in;
  logic action_request_done_in, action_request_failed_in;
  logic [3:0] fsb_valid_out, char_valid_out;
  logic [3:0][7:0] frame_status_byte_out;
  logic [3:0][15:0] char_entry_out;
  logic [31:0] reg_rdata_out, mem_wr_addr_out, mem_wr_data_out;
  logic mem_wr_valid_out, mem_wr_ready_in, vec_dropped_out, inta_n_out;
  int n_fail = 0, checks = 0, seen = 0, cyc = 0;
  int pos [0:8] = '{default: 0};
  divq_top DUT (.*);
  divq_host_mem hm (.core_clk_in, .rst_n_in,
    .mem_wr_valid_in(mem_wr_valid_out), .mem_wr_addr_in(mem_wr_addr_out),
    .mem_wr_data_in(mem_wr_data_out), .stall_in(stall), .slow_in(slow),
    .mem_wr_ready_out(mem_wr_ready_in));
  always #5 core_clk_in = ~core_clk_in;
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard well above the longest expected run
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // All event and qualifier inputs back to quiet
  task automatic clr();
    {desc_done_in, desc_host_irq_in, desc_frame_end_in, desc_hold_in} <= '0;
    {desc_last_eq_first_in, desc_count_zero_in, desc_no_fit_in} <= '0;
    {chan_irq_in, channel_irq_status_in, rx_reset_stop_in} <= '0;
    {rx_dma_reset_cmd_in, hdlc_frame_end_in, receive_overflow_flag_in} <= '0;
    {crc_ok_in, frame_aborted_flag_in, char_valid_in, char_parity_in} <= '0;
    {parity_error_flag_in, framing_error_flag_in, char_data_in} <= '0;
    {char_status_store_enable_in, action_request_done_in} <= '0;
    action_request_failed_in <= 1'b0;
  endtask
  task automatic step();
    @(posedge core_clk_in);
    clr();
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] dat);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= dat;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e,
    input string nm);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(nm, e, reg_rdata_out);
  endtask
  // Next logged write must land at the queue's running position
  task automatic xv(input int q, input logic [31:0] e);
    int k = 0;
    while (hm.n <= seen && k < 100) begin
      @(posedge core_clk_in);
      k++;
    end
    #1 chk("vec addr", 32'h1000 * (q + 1) + 4 * (pos[q] % 32), hm.wa[seen]);
    chk("vec data", e, hm.wd[seen]);
    seen++;
    pos[q]++;
  endtask
  task automatic s_regs();
    // A write while the clock enable is low must leave no trace
    clk_en_in <= 1'b0;
    wr(REG_QLEN0, 32'h0000_00ff);
    clk_en_in <= 1'b1;
    rd(REG_QLEN0, QLEN_RESET, "frozen qlen0");
    rd(REG_QLEN0, QLEN_RESET, "qlen0");
    rd(REG_MASK, MASK_RESET, "mask");
    rd(REG_QBASE0, QBASE_RESET, "qbase0");
    wr(6'h3f, 32'hffff_ffff);
    rd(6'h3f, 32'h0, "unmapped");
    for (int q = 0; q < NUM_QUEUES; q++) begin
      wr(REG_QBASE0 + 6'(q), 32'h1000 * (q + 1));
    end
    wr(REG_QLEN1, 32'h0300_0000);
    rd(REG_QLEN1, 32'h0300_0000, "qlen1");
    wr(REG_QLEN1, QLEN_RESET);
  endtask
  // Every flag combination once, two combinations per channel, both char formats
  task automatic s_bytes();
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk_in);
      {hdlc_frame_end_in, char_valid_in} <= {2{4'h1 << (i % 4)}};
      {receive_overflow_flag_in, crc_ok_in} <= {{4{i[2]}}, {4{i[1]}}};
      {frame_aborted_flag_in, char_parity_in} <= {{4{i[0]}}, {4{i[0]}}};
      {parity_error_flag_in, framing_error_flag_in} <= {{4{i[1]}}, {4{i[2]}}};
      char_status_store_enable_in <= {4{i[0]}};
      char_data_in <= {4{8'h5a ^ 8'(i)}};
      step();
      #1 chk("fsb valid", 4'h1 << (i % 4), fsb_valid_out);
      chk("fsb", {1'b1, i[2:0], 4'h0}, frame_status_byte_out[i % 4]);
      chk("char valid", 4'h1 << (i % 4), char_valid_out);
      chk("char", i[0] ? {i[1], i[2], 5'h0, i[0], 8'h5a ^ 8'(i)} :
        {8'h0, 8'h5a ^ 8'(i)}, char_entry_out[i % 4]);
    end
  endtask
  task automatic s_dma();
    @(posedge core_clk_in);
    {desc_done_in, desc_host_irq_in, desc_frame_end_in} <= {3{8'h02}};
    step();
    xv(1, 32'h1006_0000);
    rd(REG_GLOBAL_FLAGS, 32'h2, "flags");
    chk("inta", 1'b0, inta_n_out);
    wr(REG_GLOBAL_FLAGS, 32'h0);
    rd(REG_GLOBAL_FLAGS, 32'h2, "flags");
    chk("inta", 1'b0, inta_n_out);
    wr(REG_GLOBAL_FLAGS, 32'h2);
    rd(REG_GLOBAL_FLAGS, 32'h0, "flags");
    chk("inta", 1'b1, inta_n_out);
    @(posedge core_clk_in);
    {desc_done_in, desc_hold_in} <= {2{8'h10}};
    step();
    @(posedge core_clk_in);
    {desc_done_in, desc_count_zero_in} <= {2{8'h20}};
    step();
    @(posedge core_clk_in);
    {desc_done_in, desc_last_eq_first_in} <= {2{8'h40}};
    step();
    @(posedge core_clk_in);
    {desc_hold_in, desc_no_fit_in} <= {2{8'h04}};
    step();
    @(posedge core_clk_in);
    rx_dma_reset_cmd_in <= 4'h8;
    step();
    @(posedge core_clk_in);
    rx_reset_stop_in <= 4'h1;
    step();
    @(posedge core_clk_in);
    action_request_done_in <= 1'b1;
    step();
    @(posedge core_clk_in);
    action_request_failed_in <= 1'b1;
    step();
    @(posedge core_clk_in);
    chan_irq_in <= 8'h80;
    channel_irq_status_in[7] <= 19'h5_0203;
    step();
    xv(4, 32'h4001_0000);
    xv(5, 32'h5001_0000);
    xv(6, 32'h6001_0000);
    xv(2, 32'h2001_0000);
    xv(3, 32'h3001_0000);
    xv(0, 32'h0002_0000);
    xv(8, 32'ha000_0001);
    xv(8, 32'ha000_0002);
    xv(7, 32'h7205_0203);
    wr(REG_GLOBAL_FLAGS, 32'h1ff);
    rd(REG_GLOBAL_FLAGS, 32'h0, "flags");
  endtask
  task automatic s_mask();
    wr(REG_MASK, 32'h0001_0001);
    @(posedge core_clk_in);
    {desc_done_in, desc_frame_end_in} <= {2{8'h01}};
    action_request_done_in <= 1'b1;
    step();
    repeat (20) @(posedge core_clk_in);
    #1 chk("masked writes", seen, hm.n);
    chk("inta", 1'b1, inta_n_out);
    rd(REG_GLOBAL_FLAGS, 32'h0, "flags");
    wr(REG_MASK, MASK_RESET);
  endtask
  // Host stalls: fill the store until it drops, then drain slowly
  task automatic s_fifo();
    logic dr = 1'b0;
    stall <= 1'b1;
    wr(REG_QBASE0, 32'h1000);
    pos[0] = 0;
    @(posedge core_clk_in);
    {desc_done_in, desc_frame_end_in} <= {2{8'h01}};
    // Sample after the edge so the registered pulse has settled
    repeat (40) begin
      @(posedge core_clk_in);
      #1 dr |= vec_dropped_out;
    end
    @(posedge core_clk_in);
    clr();
    repeat (2) @(posedge core_clk_in);
    chk("dropped", 1'b1, dr | vec_dropped_out);
    rd(REG_FIFO_LEVEL, VFIFO_DEPTH, "level");
    @(posedge core_clk_in);
    stall <= 1'b0;
    slow <= 1'b1;
    for (int i = 0; i < 33; i++) xv(0, 32'h0002_0000);
    wr(REG_GLOBAL_FLAGS, 32'h1);
    rd(REG_FIFO_LEVEL, 32'h0, "level");
  endtask
  initial begin
    clr();
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    s_regs();
    s_bytes();
    s_dma();
    s_mask();
    s_fifo();
    end_of_test();
  end
endmodule
`default_nettype wire
